/* File: cti_defs.svh */
// constants for the output port status and interrupt block
`ifndef CTI_DEFS_SVH
`define CTI_DEFS_SVH
`define CTI_NUM_TX 2
`define CTI_NUM_RX 4
`define CTI_ADDR_PORT_SEL 8'h32
`define CTI_ADDR_STATUS 8'h35
`define CTI_ADDR_IRQ_EN 8'h36
`define CTI_ADDR_IRQ_ST 8'h37
`define CTI_ADDR_SPARE_A 8'h38
`define CTI_ADDR_SPARE_B 8'h39
`define CTI_SEL_RESET 8'h01
`define CTI_SEL_RD_BIT 4
`define CTI_SEL_WR_LSB 0
`define CTI_STS_PORT_BIT 4
`define CTI_STS_SYNC_BIT 1
`define CTI_STS_PASS_BIT 0
`define CTI_IRQ_W 5
`define CTI_IRQ_RESET 5'h00
`define CTI_IRQ_RXPORT 4
`define CTI_IRQ_SYNCERR 3
`define CTI_IRQ_SYNCED 2
`define CTI_IRQ_PASSLOST 1
`define CTI_IRQ_PASSRISE 0
`define CTI_RC_MASK 5'h0f
`endif

/* File: cti_host.sv */
// register host model for the block's access port
`timescale 1ns/1ps
module cti_host (
  input wire logic clk,
  output cti_pkg::cti_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);
  import cti_pkg::*;
  initial reg_req = '0;
  // ----------------
  // byte accesses
  // ----------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

/* File: cti_pkg.sv */
// types for the output port status and interrupt block
`include "cti_defs.svh"
package cti_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cti_reg_req_t;

  typedef struct packed {
    logic sync_ok;
    logic sync_off;
    logic sync_err;
    logic async_mode;
    logic pass_mode;
    logic tx_error;
    logic [`CTI_NUM_RX-1:0] rx_en;
    logic [`CTI_NUM_RX-1:0] rx_valid;
    logic [`CTI_NUM_RX-1:0] fwd;
    logic [`CTI_NUM_RX-1:0] rx_irq;
    logic rx_isr_read;
  } cti_tx_in_t;

  typedef struct packed {
    logic pass;
    logic sync;
    logic [`CTI_NUM_RX-1:0] valid_q;
    logic [`CTI_IRQ_W-1:0] ie;
    logic [`CTI_IRQ_W-1:0] is;
  } cti_port_st_t;

  typedef struct packed {
    logic [7:0] sel;
    cti_port_st_t [`CTI_NUM_TX-1:0] port;
    logic [7:0] rdata;
    logic irq;
  } cti_state_t;
endpackage

/* File: cti_status_irq.sv */
// output port status, interrupt enable and interrupt status registers
// Behaviour
// - each output port has its own copy; port select register picks the copy.
// - status bit 4 reads the index of the port selected for reads.
// - status bit 1 is 1 while synchronized, 0 if unsynced or disabled.
// - status bit 0 shows valid data on any or all enabled ports.
// - asynchronous forwarding: pass means delivering; an error clears it.
// - synchronized forwarding: pass means data available, sync or not.
// - five enable bits, read-write, reset 0, bit 4 down to bit 0.
// - bit 4 flags forwarded input interrupt; clears on input status read.
// - bit 3 latches a sync error and clears when read.
// - bit 2 latches sync rising and clears when read.
// - bit 1 latches valid falling on a forwarded input, clears on read.
// - bit 0 latches pass rising and clears when read.
// - pass mode 0 any enabled port valid; mode 1 every enabled port.
`timescale 1ns/1ps
`include "cti_defs.svh"
module cti_status_irq #(
  parameter int NUM_TX = 2,
  parameter int NUM_RX = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire cti_pkg::cti_reg_req_t reg_req,
  input wire cti_pkg::cti_tx_in_t [`CTI_NUM_TX-1:0] tx_in,
  output logic [7:0] reg_rdata,
  output logic irq
);
  import cti_pkg::*;

  if (NUM_TX != `CTI_NUM_TX || NUM_RX != `CTI_NUM_RX) begin : g_bad_param
    $error("cti_status_irq: port counts must match the defined structure");
  end

  // ----------------------------------------
  // state and next state
  // ----------------------------------------
  cti_state_t s;
  cti_state_t next_s;
  logic [`CTI_NUM_TX-1:0] wr_sel;
  logic rd_sel;

  assign wr_sel = s.sel[`CTI_SEL_WR_LSB +: `CTI_NUM_TX];
  assign rd_sel = s.sel[`CTI_SEL_RD_BIT];

  always_comb begin
    logic [`CTI_NUM_RX-1:0] live;
    logic any_v;
    logic all_v;
    logic raw;
    logic [`CTI_IRQ_W-1:0] set;
    logic [`CTI_IRQ_W-1:0] clr;
    logic [`CTI_IRQ_W-1:0] pend;
    live = '0;
    any_v = 1'b0;
    all_v = 1'b0;
    raw = 1'b0;
    set = '0;
    clr = '0;
    pend = '0;
    next_s = s;
    // port select register
    if (reg_req.wr && reg_req.addr == `CTI_ADDR_PORT_SEL) begin
      next_s.sel = 8'h00;
      next_s.sel[`CTI_SEL_RD_BIT] = reg_req.wdata[`CTI_SEL_RD_BIT];
      next_s.sel[`CTI_SEL_WR_LSB +: `CTI_NUM_TX] = reg_req.wdata[`CTI_SEL_WR_LSB +: `CTI_NUM_TX];
    end
    for (int i = 0; i < `CTI_NUM_TX; i++) begin
      // pass evaluation
      live = tx_in[i].rx_en & tx_in[i].rx_valid;
      any_v = |live;
      all_v = (tx_in[i].rx_en != '0) && (live == tx_in[i].rx_en);
      raw = tx_in[i].pass_mode ? all_v : any_v;
      // async error drops pass, sync mode keeps it
      next_s.port[i].pass = raw & ~(tx_in[i].async_mode & tx_in[i].tx_error);
      next_s.port[i].sync = tx_in[i].sync_ok & ~tx_in[i].sync_off;
      next_s.port[i].valid_q = tx_in[i].rx_valid & tx_in[i].fwd;
      // events
      set = '0;
      set[`CTI_IRQ_RXPORT] = |(tx_in[i].rx_irq & tx_in[i].fwd);
      set[`CTI_IRQ_SYNCERR] = tx_in[i].sync_err;
      set[`CTI_IRQ_SYNCED] = ~s.port[i].sync & next_s.port[i].sync;
      set[`CTI_IRQ_PASSLOST] = |(s.port[i].valid_q & ~next_s.port[i].valid_q);
      set[`CTI_IRQ_PASSRISE] = ~s.port[i].pass & next_s.port[i].pass;
      clr = '0;
      if (reg_req.rd && reg_req.addr == `CTI_ADDR_IRQ_ST && rd_sel == i[0]) begin
        clr = `CTI_RC_MASK;
      end
      clr[`CTI_IRQ_RXPORT] = tx_in[i].rx_isr_read;
      next_s.port[i].is = (s.port[i].is & ~clr) | set; // set wins over clear
      // per-port enable copy
      if (reg_req.wr && reg_req.addr == `CTI_ADDR_IRQ_EN && wr_sel[i]) begin
        next_s.port[i].ie = reg_req.wdata[`CTI_IRQ_W-1:0];
      end
      pend = pend | (s.port[i].ie & s.port[i].is);
    end
    next_s.irq = |pend;
    // register reads, reserved bits zero
    if (reg_req.rd) begin
      next_s.rdata = 8'h00;
      unique case (reg_req.addr)
        `CTI_ADDR_PORT_SEL: next_s.rdata = s.sel;
        `CTI_ADDR_STATUS: begin
          next_s.rdata[`CTI_STS_PORT_BIT] = rd_sel;
          next_s.rdata[`CTI_STS_SYNC_BIT] = s.port[rd_sel].sync;
          next_s.rdata[`CTI_STS_PASS_BIT] = s.port[rd_sel].pass;
        end
        `CTI_ADDR_IRQ_EN: next_s.rdata[`CTI_IRQ_W-1:0] = s.port[rd_sel].ie;
        `CTI_ADDR_IRQ_ST: next_s.rdata[`CTI_IRQ_W-1:0] = s.port[rd_sel].is;
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s.sel <= `CTI_SEL_RESET;
      for (int i = 0; i < `CTI_NUM_TX; i++) begin
        s.port[i].pass <= 1'b0;
        s.port[i].sync <= 1'b0;
        s.port[i].valid_q <= '0;
        s.port[i].ie <= `CTI_IRQ_RESET;
        s.port[i].is <= `CTI_IRQ_RESET;
      end
      s.rdata <= 8'h00;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign irq = s.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_status_port;
    reg_req.rd && reg_req.addr == `CTI_ADDR_STATUS
      |=> reg_rdata[`CTI_STS_PORT_BIT] == $past(rd_sel);
  endproperty
  a_status_port: assert property (p_status_port) else $error("port index wrong");

  property p_sync_level;
    ##1 s.port[0].sync == $past(tx_in[0].sync_ok && !tx_in[0].sync_off);
  endproperty
  a_sync_level: assert property (p_sync_level) else $error("sync level wrong");

  property p_pass_all;
    tx_in[0].pass_mode && !tx_in[0].async_mode && tx_in[0].rx_en != '0
      && (tx_in[0].rx_en & ~tx_in[0].rx_valid) == '0 |=> s.port[0].pass;
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("all mode pass missing");

  property p_pass_any_none;
    !tx_in[0].pass_mode && (tx_in[0].rx_en & tx_in[0].rx_valid) == '0 |=> !s.port[0].pass;
  endproperty
  a_pass_any_none: assert property (p_pass_any_none) else $error("stray pass");

  property p_async_err;
    tx_in[0].async_mode && tx_in[0].tx_error |=> !s.port[0].pass;
  endproperty
  a_async_err: assert property (p_async_err) else $error("error kept pass");

  property p_ie_reset;
    $fell(reset) |-> s.port[0].ie == '0 && s.port[1].ie == '0;
  endproperty
  a_ie_reset: assert property (p_ie_reset) else $error("enable not reset");

  property p_sync_latch;
    $rose(s.port[0].sync) |-> s.port[0].is[`CTI_IRQ_SYNCED];
  endproperty
  a_sync_latch: assert property (p_sync_latch) else $error("sync not latched");

  property p_syncerr_latch;
    tx_in[1].sync_err ##1 !(reg_req.rd && reg_req.addr == `CTI_ADDR_IRQ_ST && rd_sel)
      |-> s.port[1].is[`CTI_IRQ_SYNCERR] [*2];
  endproperty
  a_syncerr_latch: assert property (p_syncerr_latch) else $error("sync error lost");

  property p_rx_hold;
    s.port[0].is[`CTI_IRQ_RXPORT] && !tx_in[0].rx_isr_read |=> s.port[0].is[`CTI_IRQ_RXPORT];
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("input flag cleared early");

  property p_irq_out;
    ##1 irq == $past(|((s.port[0].ie & s.port[0].is) | (s.port[1].ie & s.port[1].is)));
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("request mismatch");

  property p_spare_zero;
    reg_req.rd && (reg_req.addr == `CTI_ADDR_SPARE_A || reg_req.addr == `CTI_ADDR_SPARE_B)
      |=> reg_rdata == 8'h00;
  endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("spare not zero");

  property p_rc_clear;
    reg_req.rd && reg_req.addr == `CTI_ADDR_IRQ_ST && !rd_sel && !tx_in[0].sync_err
      |=> !s.port[0].is[`CTI_IRQ_SYNCERR];
  endproperty
  a_rc_clear: assert property (p_rc_clear) else $error("flag not cleared");

  property p_pass_rise;
    $rose(s.port[0].pass) |-> s.port[0].is[`CTI_IRQ_PASSRISE];
  endproperty
  a_pass_rise: assert property (p_pass_rise) else $error("pass rise not latched");

  property p_pass_lost;
    (s.port[0].valid_q & ~(tx_in[0].rx_valid & tx_in[0].fwd)) != '0
      |=> s.port[0].is[`CTI_IRQ_PASSLOST];
  endproperty
  a_pass_lost: assert property (p_pass_lost) else $error("pass loss not latched");

  property p_ie_write;
    reg_req.wr && reg_req.addr == `CTI_ADDR_IRQ_EN && wr_sel[1]
      |=> s.port[1].ie == $past(reg_req.wdata[`CTI_IRQ_W-1:0]);
  endproperty
  a_ie_write: assert property (p_ie_write) else $error("enable write lost");

  c_irq_raise: cover property (!irq ##1 irq);
  c_read_clear: cover property (s.port[0].is[`CTI_IRQ_PASSRISE]
    ##1 !s.port[0].is[`CTI_IRQ_PASSRISE]);
  c_port1_read: cover property (rd_sel && reg_req.rd && reg_req.addr == `CTI_ADDR_IRQ_ST);
  c_port1_sync: cover property (s.port[1].is[`CTI_IRQ_SYNCED] && s.port[1].ie[`CTI_IRQ_SYNCED]
    ##1 irq);
endmodule

/* File: cti_status_irq_bench.sv */
// bench for the output port status and interrupt block
`timescale 1ns/1ps
`include "cti_defs.svh"
module cti_status_irq_bench;
  import cti_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  cti_reg_req_t reg_req;
  cti_tx_in_t [`CTI_NUM_TX-1:0] tx_in = '0;
  logic [7:0] reg_rdata;
  logic irq;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  cti_status_irq dut_u (.clk(clk), .reset(reset), .reg_req(reg_req), .tx_in(tx_in),
    .reg_rdata(reg_rdata), .irq(irq));
  cti_host host_u (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
  // ----------------
  // helpers
  // ----------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    cmp(d, exp);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  // ----------------
  // sequence
  // ----------------
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    chk(8'h35, 8'h00);
    chk(8'h36, 8'h00);
    host_u.wr(8'h36, 8'hff);
    chk(8'h36, 8'h1f);
    host_u.wr(8'h37, 8'hff);
    host_u.wr(8'h38, 8'hff);
    chk(8'h38, 8'h00);
    host_u.wr(8'h39, 8'hff);
    chk(8'h39, 8'h00);
    chk(8'h37, 8'h00);
    @(posedge clk);
    tx_in[0].rx_en <= 4'h3;
    tx_in[0].rx_valid <= 4'h1;
    settle();
    chk(8'h35, 8'h01);
    cmp({7'h00, irq}, 8'h01);
    chk(8'h37, 8'h01);
    chk(8'h37, 8'h00);
    settle();
    cmp({7'h00, irq}, 8'h00);
    @(posedge clk);
    tx_in[0].pass_mode <= 1'b1;
    settle();
    chk(8'h35, 8'h00);
    @(posedge clk);
    tx_in[0].rx_valid <= 4'h3;
    settle();
    chk(8'h37, 8'h01);
    @(posedge clk);
    tx_in[0].async_mode <= 1'b1;
    tx_in[0].tx_error <= 1'b1;
    settle();
    chk(8'h35, 8'h00);
    @(posedge clk);
    tx_in[0].tx_error <= 1'b0;
    settle();
    chk(8'h37, 8'h01);
    @(posedge clk);
    tx_in[0].async_mode <= 1'b0;
    tx_in[0].sync_ok <= 1'b1;
    settle();
    chk(8'h35, 8'h03);
    chk(8'h37, 8'h04);
    @(posedge clk);
    tx_in[0].sync_off <= 1'b1;
    settle();
    chk(8'h35, 8'h01);
    @(posedge clk);
    tx_in[0].sync_err <= 1'b1;
    @(posedge clk);
    tx_in[0].sync_err <= 1'b0;
    settle();
    chk(8'h37, 8'h08);
    @(posedge clk);
    tx_in[0].fwd <= 4'h1;
    settle();
    tx_in[0].rx_valid <= 4'h2;
    settle();
    chk(8'h37, 8'h02);
    @(posedge clk);
    tx_in[0].rx_irq <= 4'h1;
    settle();
    chk(8'h37, 8'h10);
    chk(8'h37, 8'h10);
    @(posedge clk);
    tx_in[0].rx_irq <= 4'h0;
    tx_in[0].rx_isr_read <= 1'b1;
    @(posedge clk);
    tx_in[0].rx_isr_read <= 1'b0;
    settle();
    chk(8'h37, 8'h00);
    host_u.wr(8'h36, 8'h00);
    tx_in[0].sync_err <= 1'b1;
    @(posedge clk);
    tx_in[0].sync_err <= 1'b0;
    settle();
    cmp({7'h00, irq}, 8'h00);
    host_u.wr(8'h32, 8'h12);
    chk(8'h32, 8'h12);
    host_u.wr(8'h36, 8'h04);
    chk(8'h35, 8'h10);
    chk(8'h36, 8'h04);
    tx_in[1].sync_ok <= 1'b1;
    tx_in[1].sync_err <= 1'b1;
    @(posedge clk);
    tx_in[1].sync_err <= 1'b0;
    settle();
    chk(8'h35, 8'h12);
    cmp({7'h00, irq}, 8'h01);
    chk(8'h37, 8'h0c);
    settle();
    cmp({7'h00, irq}, 8'h00);
    host_u.wr(8'h32, 8'h01);
    chk(8'h36, 8'h00);
    chk(8'h37, 8'h08);
    give_verdict();
  end
endmodule
